/* inc/sdd_pkg.sv */
// Package of constants and types for the sigma-delta decimator with clock divider
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
package sdd_pkg;
	// Power mode field encodings
	localparam logic [1:0] SDD_PWR_HR = 2'h2;
	localparam logic [1:0] SDD_PWR_LP = 2'h1;
	localparam logic [1:0] SDD_PWR_VLP = 2'h0;
	// Oscillator divide ratios, as log2
	localparam logic [1:0] SDD_DIV_LOG_HR = 2'h0;
	localparam logic [1:0] SDD_DIV_LOG_LP = 2'h1;
	localparam logic [1:0] SDD_DIV_LOG_VLP = 2'h2;
	// Ratio code layout: ratio = 2^(code + base)
	localparam int SDD_OSR_BASE_LOG = 7;
	localparam logic [2:0] SDD_OSR_SPLIT_CODE = 3'h3;
	localparam int SDD_SINC3_MAX_LOG = 10;
	// Settled conversions taken from the fast path
	localparam logic [1:0] SDD_FAST_CONV = 2'h2;
	// Widths: sinc3 growth 3*10+1, sinc1 adds 4 bits
	localparam int SDD_ACC_W = 32;
	localparam int SDD_OUT_W = 32;
	localparam int SDD_CNT_W = 14;
	localparam int SDD_NCH = 2;

	// Configuration carried as one group
	typedef struct packed {
		logic clk_sel;
		logic [1:0] power_mode_field;
		logic [2:0] osr_code;
	} sdd_cfg_t;

	// Output sample with its source path
	typedef struct packed {
		logic from_sinc3;
		logic [SDD_OUT_W-1:0] value;
	} sdd_sample_t;
endpackage

/* src/sdd_clkdiv.sv */
// Main and modulator clock-enable generator, divided by power mode on the oscillator only
`timescale 1ns/1ns
module sdd_clkdiv
	import sdd_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// Mode and source
	input wire logic osc_tick,
	input wire logic ext_tick,
	input wire sdd_cfg_t cfg,
	// Enables
	output logic mclk_en,
	output logic mod_en
);
	logic [1:0] div_q, div_d;
	logic half_q, half_d;
	logic [1:0] div_log;
	logic src_tick;

	//------------------------------------------------------------------
	// Divider
	//------------------------------------------------------------------
	// Source choice: no sequencer, so the host must stand by first
	always_comb begin
		src_tick = cfg.clk_sel ? osc_tick : ext_tick;
		unique case (cfg.power_mode_field)
			SDD_PWR_HR: div_log = SDD_DIV_LOG_HR;
			SDD_PWR_LP: div_log = SDD_DIV_LOG_LP;
			default: div_log = SDD_DIV_LOG_VLP; // Unused code treated as lowest power
		endcase
		div_d = div_q;
		half_d = half_q;
		mclk_en = 1'b0;
		if (src_tick) begin
			if (!cfg.clk_sel || div_q == ((2'h1 << div_log) - 2'h1)) begin
				div_d = 2'h0;
				mclk_en = 1'b1;
				half_d = ~half_q;
			end else begin
				div_d = div_q + 2'h1;
			end
		end
		mod_en = mclk_en & half_q;
	end

	// Registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			div_q <= 2'h0;
			half_q <= 1'b0;
		end else if (ce) begin
			div_q <= div_d;
			half_q <= half_d;
		end
	end
endmodule // sdd_clkdiv

/* src/sdd_decimator.sv */
// Two-channel sinc3 / fast-settling sinc1 decimator with clock division
`timescale 1ns/1ns
module sdd_decimator
	import sdd_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// Clock sources, oscillator and external clock levels, sampled as data
	input wire logic osc_pin,
	input wire logic external_clock_input,
	// Configuration
	input wire sdd_cfg_t cfg,
	// Modulator bit-streams
	input wire logic [SDD_NCH-1:0] mod_bit,
	// Sample outputs
	output sdd_sample_t [SDD_NCH-1:0] sample,
	output logic sample_valid,
	output logic mod_clk_en
);
	logic [1:0] osc_s_q, ext_s_q;
	logic osc_p_q, ext_p_q;
	logic [SDD_NCH-1:0] bit_s1_q, bit_s2_q;
	logic mclk_en, mod_en;
	logic [SDD_CNT_W-1:0] cnt_q, cnt_d;
	logic [SDD_CNT_W-1:0] s3_last, total_last;
	logic s3_dump, out_dump;
	logic [3:0] s1_log;
	int s3_shift;
	logic [1:0] conv_q, conv_d;
	logic valid_q, valid_d;

	//------------------------------------------------------------------
	// Pin synchronisers and edge ticks
	//------------------------------------------------------------------
	// Oscillator and external clock are sampled as data; two stages first
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			osc_s_q <= 2'h0;
			ext_s_q <= 2'h0;
			osc_p_q <= 1'b0;
			ext_p_q <= 1'b0;
		end else if (ce) begin
			osc_s_q <= {osc_s_q[0], osc_pin};
			ext_s_q <= {ext_s_q[0], external_clock_input};
			osc_p_q <= osc_s_q[1];
			ext_p_q <= ext_s_q[1];
		end
	end

	// Clock enables for main clock and modulator
	sdd_clkdiv sdd_clkdiv_i (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.osc_tick(osc_s_q[1] & ~osc_p_q),
		.ext_tick(ext_s_q[1] & ~ext_p_q),
		.cfg(cfg),
		.mclk_en(mclk_en),
		.mod_en(mod_en)
	);
	// Gated so that a tick held by a frozen divider is not seen outside
	assign mod_clk_en = mod_en & ce;

	//------------------------------------------------------------------
	// Decimation counter
	//------------------------------------------------------------------
	// Ratio code split: above the split code sinc3 stays at 1024
	always_comb begin
		if (cfg.osr_code > SDD_OSR_SPLIT_CODE) begin
			s3_last = SDD_CNT_W'((1 << SDD_SINC3_MAX_LOG) - 1);
			s1_log = 4'(cfg.osr_code - SDD_OSR_SPLIT_CODE);
			// Left-justify full scale: sinc3 grows 3 bits per ratio bit, sinc1 one
			s3_shift = SDD_ACC_W - 1 - 3 * SDD_SINC3_MAX_LOG - int'(s1_log);
		end else begin
			s3_last = SDD_CNT_W'((1 << (SDD_OSR_BASE_LOG + 32'(cfg.osr_code))) - 1);
			s1_log = 4'h0;
			s3_shift = SDD_ACC_W - 1 - 3 * (SDD_OSR_BASE_LOG + int'(cfg.osr_code));
		end
		total_last = SDD_CNT_W'((1 << (SDD_OSR_BASE_LOG + 32'(cfg.osr_code))) - 1);
		s3_dump = mod_en && ((cnt_q & s3_last) == s3_last);
		out_dump = mod_en && (cnt_q == total_last);
		cnt_d = cnt_q;
		if (mod_en)
			cnt_d = out_dump ? '0 : cnt_q + 1'b1;
	end

	// Modulator bits synchronised before the filters read them
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bit_s1_q <= '0;
			bit_s2_q <= '0;
		end else if (ce) begin
			bit_s1_q <= mod_bit;
			bit_s2_q <= bit_s1_q;
		end
	end

	//------------------------------------------------------------------
	// Filter channels
	//------------------------------------------------------------------
	// Both paths run in parallel on every channel
	for (genvar ch = 0; ch < SDD_NCH; ch++) begin : g_ch
		logic [SDD_ACC_W-1:0] i1_q, i2_q, i3_q, d1_q, d2_q, d3_q;
		logic [SDD_ACC_W-1:0] i1_d, i2_d, i3_d, d1_d, d2_d, d3_d;
		logic [SDD_ACC_W-1:0] c1, c2, c3, fast_q, fast_d;
		// Room for sixteen full-scale sinc3 words before the final shift
		logic [SDD_ACC_W+3:0] s1acc_q, s1acc_d, s1_sum;
		logic [SDD_ACC_W-1:0] s3_out_q, s3_out_d;
		sdd_sample_t smp_q, smp_d;

		// Integrators at modulator rate, combs at sinc3 rate
		always_comb begin
			i1_d = i1_q;
			i2_d = i2_q;
			i3_d = i3_q;
			d1_d = d1_q;
			d2_d = d2_q;
			d3_d = d3_q;
			s1acc_d = s1acc_q;
			fast_d = fast_q;
			s3_out_d = s3_out_q;
			smp_d = smp_q;
			c1 = i3_q - d1_q;
			c2 = c1 - d2_q;
			c3 = c2 - d3_q;
			s1_sum = s1acc_q + (SDD_ACC_W+4)'(c3);
			if (mod_en) begin
				// Averaging of the one's density stream
				i1_d = i1_q + SDD_ACC_W'(bit_s2_q[ch]);
				i2_d = i2_q + i1_q;
				i3_d = i3_q + i2_q;
				// Last bit of a period goes to the output, so the next count starts empty
				fast_d = out_dump ? '0 : fast_q + SDD_ACC_W'(bit_s2_q[ch]);
				if (s3_dump) begin
					d1_d = i3_q;
					d2_d = c1;
					d3_d = c2;
					s3_out_d = c3;
					s1acc_d = out_dump ? '0 : s1_sum;
				end
				if (out_dump) begin
					// Scale to common full-scale position
					smp_d.from_sinc3 = (conv_q == SDD_FAST_CONV);
					smp_d.value = (conv_q == SDD_FAST_CONV)
						? ((s3_shift >= 0) ? SDD_OUT_W'(s1_sum << s3_shift)
							: SDD_OUT_W'(s1_sum >> (-s3_shift)))
						: ((fast_q + SDD_ACC_W'(bit_s2_q[ch]))
							<< (SDD_ACC_W - 1 - SDD_OSR_BASE_LOG - 32'(cfg.osr_code)));
				end
			end
		end

		// Channel registers
		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				i1_q <= '0;
				i2_q <= '0;
				i3_q <= '0;
				d1_q <= '0;
				d2_q <= '0;
				d3_q <= '0;
				s1acc_q <= '0;
				fast_q <= '0;
				s3_out_q <= '0;
				smp_q <= '0;
			end else if (ce) begin
				i1_q <= i1_d;
				i2_q <= i2_d;
				i3_q <= i3_d;
				d1_q <= d1_d;
				d2_q <= d2_d;
				d3_q <= d3_d;
				s1acc_q <= s1acc_d;
				fast_q <= fast_d;
				s3_out_q <= s3_out_d;
				smp_q <= smp_d;
			end
		end
		assign sample[ch] = smp_q;
	end

	//------------------------------------------------------------------
	// Path selection and output strobe
	//------------------------------------------------------------------
	// Two fast conversions, then sinc3 until reset; counter saturates
	always_comb begin
		conv_d = conv_q;
		valid_d = out_dump;
		if (out_dump && conv_q != SDD_FAST_CONV)
			conv_d = conv_q + 2'h1;
	end

	// Reset restarts count and fast-path choice together
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_q <= '0;
			conv_q <= 2'h0;
			valid_q <= 1'b0;
		end else if (ce) begin
			cnt_q <= cnt_d;
			conv_q <= conv_d;
			valid_q <= valid_d;
		end
	end
	assign sample_valid = valid_q & ce;
endmodule // sdd_decimator

/* tb/sdd_chk.sv */
// Port checker for the decimator
`timescale 1ns/1ns
module sdd_chk
	import sdd_pkg::*;
(
	// Clock, reset and inputs
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic osc_pin,
	input wire logic external_clock_input,
	input wire sdd_cfg_t cfg,
	input wire logic [SDD_NCH-1:0] mod_bit,
	// Outputs
	input wire sdd_sample_t [SDD_NCH-1:0] sample,
	input wire logic sample_valid,
	input wire logic mod_clk_en
);
	logic [1:0] o_q, o_d, e_q, e_d, v_q, v_d;
	logic [3:0] s_q, s_d, ticks;
	logic [15:0] m_q, m_d;
	logic seen_q, seen_d, rise;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// Source edges per tick, ticks per sample, samples since reset
	always_comb begin
		o_d = {o_q[0], osc_pin};
		e_d = {e_q[0], external_clock_input};
		rise = cfg.clk_sel ? (o_q[0] & ~o_q[1]) : (e_q[0] & ~e_q[1]);
		s_d = mod_clk_en ? {3'h0, rise} : s_q + {3'h0, rise};
		m_d = sample_valid ? {15'h0, mod_clk_en} : m_q + {15'h0, mod_clk_en};
		v_d = (sample_valid && v_q != 2'h3) ? v_q + 2'h1 : v_q;
		seen_d = seen_q | mod_clk_en;
		ticks = (cfg.power_mode_field == SDD_PWR_HR) ? 4'h2 :
			(cfg.power_mode_field == SDD_PWR_LP) ? 4'h4 : 4'h8;
	end
	// First window after reset is partial, so seen_q masks it; frozen with the block
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			{o_q, e_q, v_q, s_q, m_q, seen_q} <= '0;
		end else if (ce) begin
			{o_q, e_q, v_q, s_q, m_q, seen_q} <= {o_d, e_d, v_d, s_d, m_d, seen_d};
		end
	end
	valid_pulse_a: assert property (sample_valid |=> !sample_valid)
		else $error("valid pulse too long");
	sample_hold_a: assert property (!sample_valid |-> $stable(sample))
		else $error("sample moved without valid");
	reset_clear_a: assert property ($fell(rst) |-> sample == '0 && !sample_valid)
		else $error("output not cleared by reset");
	osc_div_a: assert property (mod_clk_en && seen_q && cfg.clk_sel |-> s_q == ticks)
		else $error("oscillator divide wrong");
	ext_div_a: assert property (mod_clk_en && seen_q && !cfg.clk_sel |-> s_q == 4'h2)
		else $error("external divide wrong");
	osr_period_a: assert property (sample_valid |-> m_q == (16'h0080 << cfg.osr_code))
		else $error("ticks per sample wrong");
	path_sel_a: assert property (sample_valid |-> sample[0].from_sinc3 == (v_q >= SDD_FAST_CONV))
		else $error("filter path wrong");
	path_pair_a: assert property (sample_valid |-> sample[1].from_sinc3 == sample[0].from_sinc3)
		else $error("channels on different paths");
endmodule // sdd_chk

bind sdd_decimator sdd_chk sdd_chk_i (.clk(clk), .rst(rst), .ce(ce), .osc_pin(osc_pin),
	.external_clock_input(external_clock_input), .cfg(cfg), .mod_bit(mod_bit),
	.sample(sample), .sample_valid(sample_valid), .mod_clk_en(mod_clk_en));

/* tb/sdd_src_model.sv */
// Oscillator, external clock and modulator bit-stream source
`timescale 1ns/1ns
module sdd_src_model
	import sdd_pkg::*;
(
	// Bench side
	input wire logic clk,
	input wire logic use_ext,
	input wire logic mod_clk_en,
	// Toward the decimator
	output logic osc_pin,
	output logic external_clock_input,
	output logic [SDD_NCH-1:0] mod_bit
);
	logic ext_run;
	// Oscillator of two clocks period, runs free; edges fall on clk falling edges
	initial begin
		osc_pin = 1'b0;
		forever #20 osc_pin = ~osc_pin;
	end
	// External clock of five clocks, phase unrelated to clk
	initial begin
		ext_run = 1'b0;
		#7;
		forever #50 ext_run = ~ext_run;
	end
	assign external_clock_input = use_ext & ext_run; // Low when unused
	// Channel 0 all ones, channel 1 alternates each tick for half density
	logic alt_q = 1'b0;
	always @(posedge clk) if (mod_clk_en) alt_q <= ~alt_q;
	assign mod_bit = {alt_q, 1'b1};
endmodule // sdd_src_model

/* tb/test_sigma_delta_decimator_clkdiv.sv */
// Self-checking testbench for the decimator
`timescale 1ns/1ns
module test_sigma_delta_decimator_clkdiv;
	import sdd_pkg::*;
	logic clk, rst, ce, use_ext, osc_pin, external_clock_input, sample_valid, mod_clk_en;
	sdd_cfg_t cfg;
	logic [SDD_NCH-1:0] mod_bit;
	sdd_sample_t [SDD_NCH-1:0] sample;
	int n_errors = 0;
	int comparisons = 0;
	int cyc = 0;
	sdd_decimator sdd_decimator_i (.clk(clk), .rst(rst), .ce(ce), .osc_pin(osc_pin),
		.external_clock_input(external_clock_input), .cfg(cfg), .mod_bit(mod_bit),
		.sample(sample), .sample_valid(sample_valid), .mod_clk_en(mod_clk_en));
	sdd_src_model sdd_src_model_i (.clk(clk), .use_ext(use_ext), .mod_clk_en(mod_clk_en),
		.osc_pin(osc_pin), .external_clock_input(external_clock_input), .mod_bit(mod_bit));
	// 50 MHz clock and a cycle count for timing samples
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) cyc <= cyc + 1;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Settings change only under reset, as no clock sequencer exists
	task automatic restart(input sdd_cfg_t c, input logic ext);
		@(negedge clk);
		rst = 1'b1;
		cfg = c;
		use_ext = ext;
		repeat (8) @(negedge clk);
		rst = 1'b0;
	endtask
	task automatic wait_sample();
		int k;
		k = 0;
		@(negedge clk);
		while (sample_valid !== 1'b1 && k < 20000) begin
			@(negedge clk);
			k++;
		end
		chk({31'h0, sample_valid}, 32'h1);
	endtask
	// Three samples: two fast-path averages, then sinc3, last period timed
	// A nonzero hold freezes the block with ce after the second sample
	task automatic conv(input sdd_cfg_t c, input logic ext, input int per, input int hold);
		int t2;
		restart(c, ext);
		for (int i = 0; i < 3; i++) begin
			wait_sample();
			chk({31'h0, sample[0].from_sinc3}, {31'h0, i == 2});
			if (i < 2) chk(sample[0].value, 32'h8000_0000);
			if (i < 2) chk(sample[1].value, 32'h4000_0000);
			if (i == 2) chk(32'(cyc - t2), 32'(per * (128 << c.osr_code) + hold));
			t2 = cyc;
			if (i == 1 && hold > 0) begin
				// Clear of the valid cycle, so no strobe is held while frozen
				repeat (2) @(negedge clk);
				ce = 1'b0;
				repeat (hold) @(negedge clk);
				ce = 1'b1;
			end
		end
	endtask
	task automatic scen_osr();
		for (int c = 0; c < 5; c++) conv('{1'b1, SDD_PWR_HR, 3'(c)}, 1'b0, 4, 0);
	endtask
	task automatic scen_power();
		conv('{1'b1, SDD_PWR_LP, 3'h0}, 1'b0, 8, 0);
		conv('{1'b1, SDD_PWR_VLP, 3'h0}, 1'b0, 16, 0);
		conv('{1'b1, 2'h3, 3'h0}, 1'b0, 16, 0);
	endtask
	// Hold is a whole number of oscillator and external periods, so timing only shifts
	task automatic scen_ext();
		conv('{1'b0, SDD_PWR_HR, 3'h1}, 1'b1, 10, 40);
	endtask
	task automatic summarize();
		if (n_errors == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Tests need about 71000 cycles; give up well past that
	initial begin
		#1700000;
		n_errors++;
		summarize();
	end
	initial begin
		rst = 1'b1;
		ce = 1'b1;
		use_ext = 1'b0;
		cfg = '{1'b1, SDD_PWR_HR, 3'h0};
		scen_osr();
		scen_power();
		scen_ext();
		summarize();
	end
endmodule // test_sigma_delta_decimator_clkdiv
